/* File: rtl/sadc_pkg.sv */
// package of constants and carrier types for the successive-approximation converter sequencer
// assumes a single 25 MHz system clock and a byte-wide special function register port
//
// Summary of operation
// - one of eight multiplexed analog inputs is converted into an 8-bit value by successive approximation.
// - one conversion takes 19.1 us at 8.38 MHz; the approximation sequence is 19.1 us at the 25 MHz system clock rounded down to 8 steps of 59 cycles, 472 cycles.
// - the input count select register sets how many inputs convert and leaves the rest as digital port pins.
// - the analog inputs share the port 1 pins and the count select value decides how many are routed to the converter.
// - the mode register holds a channel select field picking which enabled input is converted.
// - a conversion starts on the external trigger interrupt or on a software write to the mode register.
// - at the end of a conversion the result register is loaded and the done interrupt request is raised.
// - a conversion started by the external trigger stops after the done interrupt and does not restart alone.
// - a conversion started by software repeats, updating result and interrupt, until the mode register is written again.
package sadc_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [15:0] SADC_ADDR_RESULT = 16'hFF1F;
   localparam logic [15:0] SADC_ADDR_MODE = 16'hFF80;
   localparam logic [15:0] SADC_ADDR_COUNT = 16'hFF84;
   localparam logic [7:0] SADC_MODE_RESET = 8'h01;
   localparam logic [7:0] SADC_COUNT_RESET = 8'h00;
   localparam logic [7:0] SADC_RESULT_RESET = 8'h00;
   // mode register fields
   localparam int SADC_MODE_ENABLE_BIT = 7;
   // set together with enable, the write arms the external trigger instead of starting at once
   localparam int SADC_MODE_TRIG_BIT = 6;
   localparam int SADC_MODE_CHAN_LSB = 1;
   localparam int SADC_MODE_CHAN_W = 3;
   // ************************************************************
   // timing
   // ************************************************************
   localparam real SADC_CONV_TIME_US = 19.1;
   localparam real SADC_REF_CLOCK_MHZ = 8.38;
   localparam real SADC_CLOCK_MHZ = 25.0;
   // reference cycles per conversion, rounded down as a longest time; mclk cycles come from the same time times the mclk rate
   localparam int SADC_REF_CYCLES = int'($floor(SADC_CONV_TIME_US * SADC_REF_CLOCK_MHZ));
   localparam int SADC_CONV_CYCLES = int'($floor(SADC_CONV_TIME_US * SADC_CLOCK_MHZ));
   localparam int SADC_RES_BITS = 8;
   localparam int SADC_BIT_CYCLES = SADC_CONV_CYCLES / SADC_RES_BITS;
   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic sel;
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } sadc_sfr_req_s;
   typedef struct packed {
      logic [7:0] sample_sel;
      logic [2:0] chan;
   } sadc_mux_s;
endpackage

/* File: rtl/sadc_sar_core.sv */
// successive-approximation register: one trial bit per step enable, msb first
// assumes the comparator input settles within one step period
`timescale 1ns/100ps
module sadc_sar_core #(
   parameter int WIDTH = 8
) (
   input wire logic mclk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic clear, // abandon and restart from msb
   input wire logic step, // one trial-bit decision
   input wire logic comp_hi, // comparator: analog input at or above trial
   output logic [WIDTH-1:0] trial, // present trial code to the dac
   output logic done // last bit decided, one cycle
);
   logic [WIDTH-1:0] mask_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         trial <= '0;
         mask_reg <= '0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (clear) begin
            mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
            trial <= {1'b1, {(WIDTH-1){1'b0}}};
         end else if (step && mask_reg != '0) begin
            // keep or drop the trial bit, then try the next lower one
            trial <= (comp_hi ? trial : (trial & ~mask_reg)) | (mask_reg >> 1);
            mask_reg <= mask_reg >> 1;
            done <= (mask_reg == {{(WIDTH-1){1'b0}}, 1'b1});
         end
      end
   end
endmodule // sadc_sar_core

/* File: rtl/sadc_sequencer.sv */
// converter sequencer: special function registers, start control, timing and pin routing
// assumes the comparator and dac sit outside; the trigger pin is asynchronous
`timescale 1ns/100ps
module sadc_sequencer
   import sadc_pkg::*;
#(
   parameter int CONV_CYCLES = sadc_pkg::SADC_CONV_CYCLES
) (
   input wire logic mclk, // system clock 25 MHz
   input wire logic reset_n, // async reset, active low
   input wire sadc_pkg::sadc_sfr_req_s sfr_req, // register port request
   output logic [7:0] sfr_rdata, // register read data, valid cycle after rd
   input wire logic ext_trigger_pin, // external trigger interrupt input
   input wire logic comp_hi, // analog comparator output
   output logic [7:0] dac_code, // trial code to the dac
   output sadc_pkg::sadc_mux_s mux_ctrl, // analog routing of port 1 pins
   output logic conversion_done_interrupt, // one-cycle done request
   output logic busy // conversion in progress
);
   import sadc_pkg::*;
   localparam int BIT_CYC = (CONV_CYCLES / SADC_RES_BITS) < 1 ? 1 : CONV_CYCLES / SADC_RES_BITS;

   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0] converter_mode_control_reg;
   logic [7:0] analog_input_count_select_reg;
   logic [7:0] conversion_result_reg;
   logic mode_wr;
   assign mode_wr = sfr_req.sel && sfr_req.wr && sfr_req.addr == SADC_ADDR_MODE;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         converter_mode_control_reg <= SADC_MODE_RESET;
         analog_input_count_select_reg <= SADC_COUNT_RESET;
      end else if (sfr_req.sel && sfr_req.wr) begin
         if (sfr_req.addr == SADC_ADDR_MODE) begin
            converter_mode_control_reg <= sfr_req.wdata;
         end
         if (sfr_req.addr == SADC_ADDR_COUNT) begin
            analog_input_count_select_reg <= sfr_req.wdata;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_req.sel && sfr_req.rd) begin
         case (sfr_req.addr)
            SADC_ADDR_RESULT: sfr_rdata <= conversion_result_reg;
            SADC_ADDR_MODE: sfr_rdata <= converter_mode_control_reg;
            SADC_ADDR_COUNT: sfr_rdata <= analog_input_count_select_reg;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // trigger synchroniser and edge
   // ************************************************************
   logic [2:0] trig_sync_reg;
   logic trig_level_reg;
   logic trig_rise;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         trig_sync_reg <= 3'h0;
      end else begin
         trig_sync_reg <= {trig_sync_reg[1:0], ext_trigger_pin};
      end
   end
   // the filtered level only moves once the second and third stages agree, so a runt pulse is dropped
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         trig_level_reg <= 1'b0;
      end else if (trig_sync_reg[1] == trig_sync_reg[2]) begin
         trig_level_reg <= trig_sync_reg[2];
      end
   end
   assign trig_rise = trig_sync_reg[1] && trig_sync_reg[2] && !trig_level_reg;

   // ************************************************************
   // sequence control
   // ************************************************************
   typedef enum logic [1:0] {SADC_IDLE, SADC_CONVERT, SADC_FINISH} sadc_state_e;
   sadc_state_e state_reg;
   logic sw_mode_reg;
   logic [15:0] step_cnt_reg;
   logic sar_clear, sar_step, sar_done;
   logic [7:0] trial;
   logic enabled;
   logic trig_armed;
   logic [2:0] chan;
   assign enabled = converter_mode_control_reg[SADC_MODE_ENABLE_BIT];
   // without an armed mode a trigger start could never be reached, as an enabling write starts at once
   assign trig_armed = enabled && converter_mode_control_reg[SADC_MODE_TRIG_BIT];
   assign chan = converter_mode_control_reg[SADC_MODE_CHAN_LSB +: SADC_MODE_CHAN_W];
   assign sar_step = state_reg == SADC_CONVERT && step_cnt_reg == 16'(BIT_CYC - 1);
   // a mode write always restarts; a trigger only starts from idle
   assign sar_clear = mode_wr || (state_reg == SADC_IDLE && trig_armed && trig_rise) ||
                      (state_reg == SADC_FINISH && sw_mode_reg && enabled);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= SADC_IDLE;
         sw_mode_reg <= 1'b0;
      end else if (mode_wr) begin
         // new write abandons the running conversion
         // an armed write waits in idle for the trigger
         state_reg <= (sfr_req.wdata[SADC_MODE_ENABLE_BIT] && !sfr_req.wdata[SADC_MODE_TRIG_BIT]) ?
                      SADC_CONVERT : SADC_IDLE;
         sw_mode_reg <= !sfr_req.wdata[SADC_MODE_TRIG_BIT];
      end else begin
         case (state_reg)
            SADC_IDLE: begin
               if (trig_armed && trig_rise) begin
                  state_reg <= SADC_CONVERT;
                  sw_mode_reg <= 1'b0;
               end
            end
            SADC_CONVERT: begin
               if (sar_done) begin
                  state_reg <= SADC_FINISH;
               end
            end
            SADC_FINISH: begin
               // software start repeats, trigger start stops
               state_reg <= (sw_mode_reg && enabled) ? SADC_CONVERT : SADC_IDLE;
            end
            default: state_reg <= SADC_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         step_cnt_reg <= 16'h0000;
      end else if (sar_clear || sar_step || state_reg != SADC_CONVERT) begin
         step_cnt_reg <= 16'h0000;
      end else begin
         step_cnt_reg <= step_cnt_reg + 16'h0001;
      end
   end

   sadc_sar_core #(.WIDTH(SADC_RES_BITS)) u_sar (
      .mclk(mclk),
      .reset_n(reset_n),
      .clear(sar_clear),
      .step(sar_step),
      .comp_hi(comp_hi),
      .trial(trial),
      .done(sar_done)
   );

   // ************************************************************
   // result, interrupt and outputs
   // ************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         conversion_result_reg <= SADC_RESULT_RESET;
         conversion_done_interrupt <= 1'b0;
      end else begin
         conversion_done_interrupt <= sar_done && !mode_wr;
         if (sar_done && !mode_wr) begin
            conversion_result_reg <= trial;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dac_code <= 8'h00;
         busy <= 1'b0;
         mux_ctrl <= '0;
      end else begin
         dac_code <= trial;
         busy <= state_reg != SADC_IDLE;
         mux_ctrl.chan <= chan;
         for (int i = 0; i < 8; i++) begin
            // count value n routes pins 0..n-1 to the converter, 8 and above route all
            mux_ctrl.sample_sel[i] <= (analog_input_count_select_reg > 8'(i));
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   // cycles since the last restart of the approximation, saturating
   logic [15:0] conv_age_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         conv_age_reg <= 16'h0000;
      end else if (sar_clear) begin
         conv_age_reg <= 16'h0000;
      end else if (conv_age_reg != 16'hFFFF) begin
         conv_age_reg <= conv_age_reg + 16'h0001;
      end
   end
   sequence s_done_seen;
      sar_done && !mode_wr;
   endsequence
   result_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
      s_done_seen |=> conversion_result_reg == $past(trial) && conversion_done_interrupt)
      else $error("result not loaded at done");
   irq_cause_a: assert property (@(posedge mclk) disable iff (!reset_n)
      conversion_done_interrupt |-> $past(sar_done))
      else $error("interrupt without done");
   trig_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg == SADC_FINISH && !sw_mode_reg && !mode_wr |=> state_reg == SADC_IDLE)
      else $error("trigger conversion restarted");
   sw_repeat_a: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg == SADC_FINISH && sw_mode_reg && enabled && !mode_wr |=> state_reg == SADC_CONVERT)
      else $error("software conversion not repeated");
   write_restart_a: assert property (@(posedge mclk) disable iff (!reset_n)
      mode_wr && sfr_req.wdata[SADC_MODE_ENABLE_BIT] && !sfr_req.wdata[SADC_MODE_TRIG_BIT] |=>
      state_reg == SADC_CONVERT && step_cnt_reg == 16'h0000)
      else $error("write did not restart");
   trig_start_a: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg == SADC_IDLE && trig_armed && trig_rise && !mode_wr |=> state_reg == SADC_CONVERT)
      else $error("trigger did not start");
   arm_wait_a: assert property (@(posedge mclk) disable iff (!reset_n)
      mode_wr && sfr_req.wdata[SADC_MODE_TRIG_BIT] |=> state_reg == SADC_IDLE)
      else $error("armed write started a conversion");
   trig_once_a: assert property (@(posedge mclk) disable iff (!reset_n)
      trig_rise |=> !trig_rise)
      else $error("trigger edge seen twice");
   conv_exact_a: assert property (@(posedge mclk) disable iff (!reset_n)
      sar_done |-> conv_age_reg == 16'(SADC_RES_BITS * BIT_CYC))
      else $error("conversion length wrong");
   conv_len_a: assert property (@(posedge mclk) disable iff (!reset_n)
      sar_clear ##1 (!sar_clear && !mode_wr) [*7] |-> !sar_done)
      else $error("conversion ended too early");
   pin_route_a: assert property (@(posedge mclk) disable iff (!reset_n)
      ##1 mux_ctrl.sample_sel[0] == ($past(analog_input_count_select_reg) != 8'h00))
      else $error("port 1 routing wrong");
endmodule // sadc_sequencer

/* File: test/sadc_analog_model.sv */
// behavioural analog front end: port 1 pins, input multiplexer and comparator
// assumes levels hold still over a conversion and the trial code settles within one step
`timescale 1ns/100ps
module sadc_analog_model
   import sadc_pkg::*;
(
   input wire logic [7:0][7:0] lvl, // analog level per port 1 pin
   input wire sadc_pkg::sadc_mux_s mux_ctrl, // routing and channel select
   input wire logic [7:0] dac_code, // trial code from the converter
   output logic comp_hi // selected pin at or above trial code
);
   // an unrouted pin stays digital, so the comparator sees ground and a result collapses to zero
   assign comp_hi = mux_ctrl.sample_sel[mux_ctrl.chan] ? (lvl[mux_ctrl.chan] >= dac_code) : 1'b0;
endmodule // sadc_analog_model

/* File: test/sar_adc_sequencer_tb_top.sv */
// self-checking bench for the converter sequencer
// assumes the analog model stands in for the pins, multiplexer and comparator
`timescale 1ns/100ps
module sar_adc_sequencer_tb_top;
   import sadc_pkg::*;
   // short conversion keeps the run brief; all timing expectations derive from it
   localparam int CC = 32;
   localparam int BIT = CC / 8;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   sadc_sfr_req_s sfr_req = '0;
   logic ext_trigger_pin = 1'b0;
   logic [7:0][7:0] lvl = {8'hFF, 8'h11, 8'h3C, 8'h80, 8'h01, 8'hA5, 8'h7E, 8'h00};
   logic [7:0] sfr_rdata;
   logic [7:0] dac_code;
   logic comp_hi;
   logic conversion_done_interrupt;
   logic busy;
   sadc_mux_s mux_ctrl;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;
   int k;
   always #20 mclk = ~mclk;
   sadc_sequencer #(.CONV_CYCLES(CC)) DUT (.mclk(mclk), .reset_n(reset_n), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .ext_trigger_pin(ext_trigger_pin), .comp_hi(comp_hi), .dac_code(dac_code),
      .mux_ctrl(mux_ctrl), .conversion_done_interrupt(conversion_done_interrupt), .busy(busy));
   sadc_analog_model u_front (.lvl(lvl), .mux_ctrl(mux_ctrl), .dac_code(dac_code), .comp_hi(comp_hi));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic results();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk);
      sfr_req = '{sel: 1'b1, wr: w, rd: ~w, addr: a, wdata: d};
      @(negedge mclk);
      sfr_req = '0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(sfr_rdata, exp);
   endtask
   // the done pulse must last a single cycle
   task automatic wait_done(output int c);
      c = 0;
      while (conversion_done_interrupt !== 1'b1 && c < 200) begin
         @(negedge mclk);
         c++;
      end
      @(negedge mclk);
      chk({7'h00, conversion_done_interrupt}, 8'h00);
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         results();
      end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (3) @(negedge mclk);
      reset_n = 1'b1;
      rd(SADC_ADDR_MODE, SADC_MODE_RESET);
      rd(SADC_ADDR_COUNT, SADC_COUNT_RESET);
      acc(1'b1, SADC_ADDR_RESULT, 8'h5A);
      rd(SADC_ADDR_RESULT, SADC_RESULT_RESET);
      rd(16'hFF81, 8'h00);
      for (int i = 0; i <= 9; i++) begin
         acc(1'b1, SADC_ADDR_COUNT, 8'(i));
         @(negedge mclk);
         chk(mux_ctrl.sample_sel, 8'((16'h0001 << i) - 16'h0001));
      end
      acc(1'b1, SADC_ADDR_COUNT, 8'h08);
      for (int c = 0; c < 8; c++) begin
         acc(1'b1, SADC_ADDR_MODE, 8'h80 | 8'(c << 1));
         wait_done(n);
         chk(8'(n >= 8 * BIT && n <= 8 * BIT + 4), 8'h01);
         chk({5'h00, mux_ctrl.chan}, 8'(c));
         rd(SADC_ADDR_RESULT, lvl[c]);
      end
      lvl[7] = 8'h42;
      wait_done(n);
      wait_done(n);
      chk(8'(n >= 8 * BIT && n <= 8 * BIT + 4), 8'h01);
      rd(SADC_ADDR_RESULT, 8'h42);
      // restart in mid-conversion must take a whole conversion time again
      repeat (3 * BIT) @(negedge mclk);
      acc(1'b1, SADC_ADDR_MODE, 8'h84);
      wait_done(n);
      chk(8'(n >= 8 * BIT && n <= 8 * BIT + 4), 8'h01);
      rd(SADC_ADDR_RESULT, 8'hA5);
      acc(1'b1, SADC_ADDR_MODE, 8'h04);
      rd(SADC_ADDR_MODE, 8'h04);
      @(negedge mclk);
      chk({7'h00, busy}, 8'h00);
      ext_trigger_pin = 1'b1;
      k = 0;
      repeat (3 * CC) begin
         @(negedge mclk);
         k += int'(conversion_done_interrupt === 1'b1);
      end
      ext_trigger_pin = 1'b0;
      chk(8'(k), 8'h00);
      // armed for the trigger: the write alone must leave the converter idle
      acc(1'b1, SADC_ADDR_MODE, 8'hC8);
      repeat (4) @(negedge mclk);
      chk({7'h00, busy}, 8'h00);
      for (int t = 0; t < 2; t++) begin
         ext_trigger_pin = 1'b1;
         wait_done(n);
         // three synchroniser stages add a few cycles before the start; the filter adds none
         chk(8'(n >= 8 * BIT + 3 && n <= 8 * BIT + 7), 8'h01);
         rd(SADC_ADDR_RESULT, lvl[4]);
         // the pin stays high, so no new edge exists and nothing may start
         k = 0;
         repeat (3 * CC) begin
            @(negedge mclk);
            k += int'(conversion_done_interrupt === 1'b1);
         end
         chk(8'(k), 8'h00);
         chk({7'h00, busy}, 8'h00);
         ext_trigger_pin = 1'b0;
         lvl[4] = 8'h5C;
         repeat (4) @(negedge mclk);
      end
      results();
   end
endmodule // sar_adc_sequencer_tb_top
